// *** verification/prss_synth_model.sv ***
// Model of the synthesizer and digital PLL datapath.
// Assumes one aclk; the bench steers reference, lock and range.
`timescale 1ns/1ps
`default_nettype none
module prss_synth_model #(
  parameter logic [31:0] DPLL_WORD = 32'h0123_4560
) (
  input  wire logic        aclk,
  input  wire logic        ref_on,
  input  wire logic        lock_on,
  input  wire logic [1:0]  range,
  output logic             ref_present,
  output logic      [1:0]  input_range_indicator,
  output logic             pll_locked,
  output logic      [31:0] dpll_ratio,
  output logic             synth_clk
);
  initial synth_clk = 1'b0;
  initial dpll_ratio = DPLL_WORD;
  always @(posedge aclk) begin
    synth_clk <= ~synth_clk;
    ref_present <= ref_on;
    input_range_indicator <= range;
    pll_locked <= lock_on;
    // No reference: word keeps moving
    dpll_ratio <= ref_on ? DPLL_WORD : ~dpll_ratio;
  end
endmodule // prss_synth_model
`default_nettype wire

// *** verification/prss_top_assertions.sv ***
// Checker for the ratio and source select block; top ports only.
// Assumes full-strobe config writes and at most one write in flight.
`timescale 1ns/1ps
`default_nettype none
module prss_top_assertions #(
  parameter int LOSS_WAIT_CYCLES = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        ref_present,
  input wire logic        pll_locked,
  input wire logic [31:0] dpll_ratio,
  input wire logic        synth_clk,
  input wire logic [31:0] frac_n_value,
  input wire logic        frac_n_dynamic,
  input wire logic        pll_clk_out,
  input wire logic        pll_clk_out_en_n
);
  // ----------------------------------------------------------------------
  // Config shadow, one cycle late
  // ----------------------------------------------------------------------
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [13:0] cfg_q;
  logic [2:0]  quiet_q;
  logic        bv_q;
  int          lost_q;
  wire         auto_w  = cfg_q[1:0] != cfg_q[3:2];
  wire         quiet_w = quiet_q == 3'h7;
  always_ff @(posedge aclk) begin
    bv_q <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cfg_q <= 14'h0000;
    else if (s_axi_bvalid && !bv_q && aw_q == prss_pkg::PRSS_OFS_CONFIG) cfg_q <= w_q[13:0];
  end
  // Settle time covers shadow lag and pipeline
  always_ff @(posedge aclk) begin
    if (!aresetn || s_axi_bvalid) quiet_q <= 3'h0;
    else if (!quiet_w) quiet_q <= quiet_q + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || s_axi_bvalid || ref_present || !auto_w) lost_q <= 0;
    else if (lost_q < 1000) lost_q <= lost_q + 1;
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_unl_low: assert property ((!pll_locked)[*4] ##0 (!cfg_q[11] && !s_axi_bvalid) |-> !pll_clk_out)
    else $error("unlocked output not low");
  a_unl_open: assert property ((!pll_locked)[*4] ##0 (cfg_q[11] && !s_axi_bvalid && synth_clk) |-> pll_clk_out)
    else $error("unlock pass blocked");
  a_lock_pass: assert property (pll_locked[*4] ##0 synth_clk |-> pll_clk_out)
    else $error("locked output blocked");
  a_dis_float: assert property (!s_axi_bvalid |-> pll_clk_out_en_n == cfg_q[10])
    else $error("enable not following disable");
  a_manual_src: assert property (quiet_w && !auto_w |-> frac_n_dynamic == cfg_q[7])
    else $error("manual source ignored");
  a_auto_ref: assert property ((quiet_w && auto_w && ref_present)[*6] |-> frac_n_dynamic)
    else $error("no dynamic with reference");
  a_loss_hold: assert property ($fell(ref_present) && frac_n_dynamic && auto_w && quiet_w |=> frac_n_dynamic[*8])
    else $error("static source too early");
  a_loss_static: assert property (lost_q >= LOSS_WAIT_CYCLES + 6 |-> !frac_n_dynamic)
    else $error("static source too late");
  a_ref_return: assert property ($rose(ref_present) && auto_w && quiet_w |-> ##[1:8] frac_n_dynamic)
    else $error("dynamic not restored");
  a_dyn_value: assert property ((frac_n_dynamic && $stable(dpll_ratio))[*4] |-> frac_n_value == dpll_ratio)
    else $error("word not from digital PLL");
  c_auto_loss: cover property ($fell(frac_n_dynamic) && auto_w);
  c_ref_back: cover property ($rose(frac_n_dynamic) && auto_w);
  c_unl_open: cover property (cfg_q[11] && pll_clk_out && !pll_locked);
endmodule // prss_top_assertions
bind prss_top prss_top_assertions #(.LOSS_WAIT_CYCLES(LOSS_WAIT_CYCLES)) assert_u (.*);
`default_nettype wire

// *** verification/tb_pll_ratio_source_select.sv ***
// Testbench for the ratio and source select block over AXI4-Lite.
// Assumes 125 MHz aclk and a shortened loss wait.
`timescale 1ns/1ps
`default_nettype none
module tb_pll_ratio_source_select;
  localparam int LOSS = 16;
  localparam logic [31:0] DPLL = 32'h0123_4560;
  localparam logic [7:0] EFF = prss_pkg::PRSS_OFS_EFFECT;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ref_on, lock_on;
  logic        awready, wready, bvalid, arready, rvalid, ref_present, pll_locked;
  logic        synth_clk, fn_dyn, clk_out, out_en_n;
  logic [1:0]  bresp, rresp, range_v, range_ind, r;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, dpll_ratio, fn_value, q;
  int          bad_count, compares, m, dv, rg, f;
  prss_top #(.LOSS_WAIT_CYCLES(LOSS)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ref_present, .input_range_indicator(range_ind),
    .pll_locked, .dpll_ratio, .synth_clk,
    .frac_n_value(fn_value), .frac_n_dynamic(fn_dyn), .pll_clk_out(clk_out), .pll_clk_out_en_n(out_en_n));
  prss_synth_model #(.DPLL_WORD(DPLL)) model_u (
    .aclk, .ref_on(ref_on), .lock_on(lock_on), .range(range_v), .ref_present,
    .input_range_indicator(range_ind), .pll_locked, .dpll_ratio, .synth_clk);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task conclude;
    $display("counts compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    if (w) begin
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    end else begin
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    end
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (w && bvalid) begin
        r = bresp; bready <= 1'b0; break;
      end
      if (!w && rvalid) begin
        r = rresp; q = rdata; rready <= 1'b0; break;
      end
    end
    if (n == 64) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    xfer(1'b1, a, d);
    chk(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
    xfer(1'b0, a, 32'h0);
    chk(q, ed);
    chk(32'(r), 32'(er));
  endtask
  task automatic wcfg(input logic [31:0] d);
    wr(prss_pkg::PRSS_OFS_CONFIG, d);
    tick(6);
  endtask
  task automatic clks(input logic p);
    repeat (4) begin
      @(posedge aclk);
      chkb(clk_out, p & synth_clk);
    end
  endtask
  function automatic logic [31:0] cw(logic [1:0] rs, ds, logic [2:0] md, logic s, au, fm, dis, unl, logic [1:0] d);
    return {18'h0, d, unl, dis, fm, au, s, md, ds, rs};
  endfunction
  function automatic logic [31:0] eff(logic [31:0] u, logic [2:0] md, logic [1:0] d, logic au, logic [1:0] g, logic dyn, fm);
    logic [31:0] v;
    v = (dyn && !fm) ? u << 8 : u;
    v = md[2] ? v >> (md - 3'd3) : v << md;
    if (dyn && au) v = v >> (g == 2'b11 ? 2'd0 : g);
    return v << d;
  endfunction
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    bad_count = 0; compares = 0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    ref_on = 1'b0; lock_on = 1'b0; range_v = 2'b00;
    tick(12);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(4 * i), prss_pkg::PRSS_RATIO_RESET);
    rd(prss_pkg::PRSS_OFS_CONFIG, 32'h0);
    wr(8'h1c, 32'hffff_ffff, prss_pkg::PRSS_RESP_SLVERR);
    rd(8'h1c, 32'h0, prss_pkg::PRSS_RESP_SLVERR);
    $display("test reset done");
    // Static: auto modifier enabled, must not act
    range_v <= 2'b01;
    wr(prss_pkg::PRSS_OFS_RATIO2, 32'h0030_0000);
    for (m = 0; m < 8; m++) for (dv = 0; dv < 4; dv++) begin
      wcfg(cw(2, 2, m, 0, 1, 0, 0, 0, dv));
      rd(EFF, eff(32'h0030_0000, m, dv, 1, 1, 0, 0));
      chk(fn_value, eff(32'h0030_0000, m, dv, 1, 1, 0, 0));
      chkb(fn_dyn, 1'b0);
    end
    $display("test static done");
    ref_on <= 1'b1;
    wr(prss_pkg::PRSS_OFS_RATIO1, 32'h0001_0000);
    for (rg = 0; rg < 3; rg++) for (f = 0; f < 2; f++) begin
      range_v <= rg;
      wcfg(cw(1, 1, 0, 1, 1, f, 0, 0, 0));
      rd(EFF, eff(32'h0001_0000, 0, 0, 1, rg, 1, f));
      chkb(fn_dyn, 1'b1);
      chk(fn_value, DPLL);
    end
    $display("test dynamic done");
    ref_on <= 1'b0;
    wr(prss_pkg::PRSS_OFS_RATIO0, 32'h0020_0000);
    wr(prss_pkg::PRSS_OFS_RATIO3, 32'h0001_0000);
    wcfg(cw(0, 3, 0, 0, 0, 1, 0, 0, 0));
    tick(LOSS);
    chkb(fn_dyn, 1'b0);
    ref_on <= 1'b1;
    tick(8);
    chkb(fn_dyn, 1'b1);
    rd(EFF, eff(32'h0001_0000, 0, 0, 0, 0, 1, 1));
    ref_on <= 1'b0;
    tick(LOSS - 4);
    chkb(fn_dyn, 1'b1);
    tick(12);
    chkb(fn_dyn, 1'b0);
    chk(fn_value, 32'h0020_0000);
    wcfg(cw(0, 3, 0, 1, 0, 0, 0, 0, 0));
    chkb(fn_dyn, 1'b0);
    rd(EFF, 32'h0020_0000);
    ref_on <= 1'b1;
    tick(8);
    chkb(fn_dyn, 1'b1);
    rd(EFF, eff(32'h0001_0000, 0, 0, 0, 0, 1, 0));
    $display("test auto done");
    wcfg(cw(0, 0, 0, 0, 0, 0, 0, 0, 0));
    clks(1'b0);
    lock_on <= 1'b1;
    tick(4);
    clks(1'b1);
    lock_on <= 1'b0;
    wcfg(cw(0, 0, 0, 0, 0, 0, 0, 1, 0));
    clks(1'b1);
    wcfg(cw(0, 0, 0, 0, 0, 0, 1, 1, 0));
    chkb(out_en_n, 1'b1);
    $display("test output done");
    conclude();
  end
endmodule // tb_pll_ratio_source_select
`default_nettype wire

// *** verilog/prss_cfg_if.sv ***
// Interface carrying decoded configuration from the register slave to the
// ratio datapath. Single aclk domain assumed.
`timescale 1ns/1ps
`default_nettype none
interface prss_cfg_if;
  logic [31:0] ratio [4];
  logic [1:0]  ratio_select;
  logic [1:0]  dynamic_ratio_select;
  logic [2:0]  manual_modifier_select;
  logic        synth_source_select;
  logic        auto_modifier_enable;
  logic        ratio_format_select;
  logic [1:0]  reference_divider_select;
  modport regs (output ratio, ratio_select, dynamic_ratio_select, manual_modifier_select,
                output synth_source_select, auto_modifier_enable, ratio_format_select,
                output reference_divider_select);
  modport core (input ratio, ratio_select, dynamic_ratio_select, manual_modifier_select,
                input synth_source_select, auto_modifier_enable, ratio_format_select,
                input reference_divider_select);
endinterface : prss_cfg_if
`default_nettype wire

// *** verilog/prss_pkg.sv ***
// Package for the ratio and source select block: register map, field layout,
// reset values and timing constants.
// Assumes a 125 MHz aclk and 32-bit AXI4-Lite register access.
package prss_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRSS_OFS_RATIO0  = 8'h00;
  localparam logic [7:0] PRSS_OFS_RATIO1  = 8'h04;
  localparam logic [7:0] PRSS_OFS_RATIO2  = 8'h08;
  localparam logic [7:0] PRSS_OFS_RATIO3  = 8'h0c;
  localparam logic [7:0] PRSS_OFS_CONFIG  = 8'h10;
  localparam logic [7:0] PRSS_OFS_STATUS  = 8'h14;
  localparam logic [7:0] PRSS_OFS_EFFECT  = 8'h18;

  // ----------------------------------------------------------------------
  // Config register fields
  // ----------------------------------------------------------------------
  localparam int PRSS_CFG_RSEL_LSB    = 0;   // ratio_select[1:0]
  localparam int PRSS_CFG_DSEL_LSB    = 2;   // dynamic_ratio_select[1:0]
  localparam int PRSS_CFG_MOD_LSB     = 4;   // manual_modifier_select[2:0]
  localparam int PRSS_CFG_SRC_BIT     = 7;   // synth_source_select
  localparam int PRSS_CFG_AUTO_BIT    = 8;   // auto_modifier_enable
  localparam int PRSS_CFG_FMT_BIT     = 9;   // ratio_format_select
  localparam int PRSS_CFG_DIS_BIT     = 10;  // pll_output_disable
  localparam int PRSS_CFG_UNL_BIT     = 11;  // output_on_unlock_enable
  localparam int PRSS_CFG_RDIV_LSB    = 12;  // reference_divider_select[1:0]
  localparam int PRSS_CFG_WIDTH       = 14;
  localparam logic [13:0] PRSS_CFG_RESET = 14'h0000;
  localparam logic [31:0] PRSS_RATIO_RESET = 32'h0010_0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PRSS_LOSS_WAIT_CYCLES = 8388608;  // 2**23 system clock cycles
  localparam int PRSS_CNT_WIDTH        = 24;

  localparam logic [1:0] PRSS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PRSS_RESP_SLVERR = 2'b10;

endpackage : prss_pkg

// *** verilog/prss_ratio_calc.sv ***
// Effective ratio arithmetic: applies modifiers and divider compensation.
// Assumes inputs are stable registers on aclk; result is registered.
`timescale 1ns/1ps
`default_nettype none
module prss_ratio_calc (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] user_ratio,
  input  wire logic [2:0]  manual_modifier_select,
  input  wire logic        apply_auto,
  input  wire logic [1:0]  input_range_indicator,
  input  wire logic        wide_format,
  input  wire logic [1:0]  reference_divider_select,
  output logic      [31:0] effective_ratio
);
  // ----------------------------------------------------------------------
  // Modifier as a signed power of two
  // ----------------------------------------------------------------------
  // 000..011 multiply by 1..8, 100..111 divide by 2..16
  wire logic [2:0] man_up = manual_modifier_select[2] ? 3'd0 : {1'b0, manual_modifier_select[1:0]};
  wire logic [2:0] man_dn = manual_modifier_select[2] ? {1'b0, manual_modifier_select[1:0]} + 3'd1 : 3'd0;
  // Auto modifier only in dynamic mode; code 11 treated as 1
  wire logic [1:0] auto_dn = (apply_auto && input_range_indicator != 2'b11) ?
                             input_range_indicator : 2'b00;
  // 20.12 puts the point 8 places lower; normalise to 12.20 internally
  wire logic [3:0] fmt_up = wide_format ? 4'd8 : 4'd0;

  // Divider compensation: a divided reference needs a proportionally larger word
  wire logic [5:0] up_sh = {3'd0, man_up} + {2'd0, fmt_up} + {4'd0, reference_divider_select};
  wire logic [5:0] dn_sh = {3'd0, man_dn} + {4'd0, auto_dn};

  // Overflow wraps silently: keeping headroom is software's job
  wire logic [63:0] wide  = {32'd0, user_ratio} << up_sh;
  wire logic [63:0] shrd  = wide >> dn_sh;

  always_ff @(posedge aclk) begin
    if (!aresetn) effective_ratio <= 32'h0000_0000;
    else          effective_ratio <= shrd[31:0];
  end
endmodule : prss_ratio_calc
`default_nettype wire

// *** verilog/prss_top.sv ***
// Ratio and fractional-N source selection block with AXI4-Lite registers.
// Assumes aclk is the system timing clock; frequency reference presence,
// lock and range code come from the PLL datapath and are resynchronised.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Static mode: effective ratio equals user ratio times manual modifier.
// - Dynamic mode: user ratio times manual modifier times automatic modifier.
// - Internal divider settings are compensated; stored ratios need no adjustment.
// - Ratio select picks the entry; dynamic select also used when auto active.
// - Fractional-N value is effective ratio or digital PLL output.
// - Manual mode: source bit selects; both select fields must be equal.
// - Auto source selection active exactly when the two select fields differ.
// - In auto mode the manual source bit is ignored.
// - Auto mode: reference present uses dynamic, absent uses static.
// - Auto mode: static from ratio select, dynamic from dynamic select.
// - After reference loss wait 2**23 clocks before going static.
// - Manual modifier in both modes; automatic modifier only dynamic.
// - Ratio format bit matters only in dynamic mode.
// - Output buffers synthesizer clock; disable bit floats the driver.
// - Output held low while unlocked by default.
// - Output-on-unlock bit lets the unreliable clock pass.
// - Ratios are 32-bit unsigned fixed point, 12.20 high resolution.
// - 20.12 only with format bit clear and dynamic source; else 12.20.
// - Manual modifier codes give 1,2,4,8,0.5,0.25,0.125,0.0625; default 1.
// - Automatic modifier 1, 0.5, 0.25 for range codes 00, 01, 10.
module prss_top #(
  parameter int LOSS_WAIT_CYCLES = prss_pkg::PRSS_LOSS_WAIT_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ref_present,
  input  wire logic [1:0]  input_range_indicator,
  input  wire logic        pll_locked,
  input  wire logic [31:0] dpll_ratio,
  input  wire logic        synth_clk,
  output logic      [31:0] frac_n_value,
  output logic             frac_n_dynamic,
  output logic             pll_clk_out,
  output logic             pll_clk_out_en_n
);
  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  initial begin
    if (LOSS_WAIT_CYCLES < 1 || LOSS_WAIT_CYCLES >= (1 << prss_pkg::PRSS_CNT_WIDTH))
      $error("LOSS_WAIT_CYCLES out of range");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {pll_locked, input_range_indicator, ref_present};
      sync2_q <= sync1_q;
    end
  end
  wire logic       ref_seen   = sync2_q[0];
  wire logic [1:0] range_code = sync2_q[2:1];
  wire logic       locked     = sync2_q[3];

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [31:0] ratio_q [4];
  logic [13:0] cfg_q;
  prss_cfg_if cfg ();

  assign cfg.ratio                    = ratio_q;
  assign cfg.ratio_select             = cfg_q[prss_pkg::PRSS_CFG_RSEL_LSB +: 2];
  assign cfg.dynamic_ratio_select     = cfg_q[prss_pkg::PRSS_CFG_DSEL_LSB +: 2];
  assign cfg.manual_modifier_select   = cfg_q[prss_pkg::PRSS_CFG_MOD_LSB +: 3];
  assign cfg.synth_source_select      = cfg_q[prss_pkg::PRSS_CFG_SRC_BIT];
  assign cfg.auto_modifier_enable     = cfg_q[prss_pkg::PRSS_CFG_AUTO_BIT];
  assign cfg.ratio_format_select      = cfg_q[prss_pkg::PRSS_CFG_FMT_BIT];
  assign cfg.reference_divider_select = cfg_q[prss_pkg::PRSS_CFG_RDIV_LSB +: 2];
  wire logic pll_output_disable      = cfg_q[prss_pkg::PRSS_CFG_DIS_BIT];
  wire logic output_on_unlock_enable = cfg_q[prss_pkg::PRSS_CFG_UNL_BIT];

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  // Address and data are taken separately, in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  wire logic aw_fire   = s_axi_awvalid && s_axi_awready;
  wire logic w_fire    = s_axi_wvalid && s_axi_wready;
  wire logic wr_go     = aw_held_q && w_held_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return a[7:2] <= prss_pkg::PRSS_OFS_EFFECT[7:2];
  endfunction

  wire logic       wr_ratio = wr_go && aw_addr_q[7:4] == 4'h0;
  wire logic [1:0] wr_idx   = aw_addr_q[3:2];
  wire logic       wr_cfg   = wr_go && aw_addr_q[7:2] == prss_pkg::PRSS_OFS_CONFIG[7:2];
  wire logic [31:0] cfg_wide = merge({18'd0, cfg_q}, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_fire) aw_addr_q <= s_axi_awaddr;
      if (w_fire) w_data_q <= s_axi_wdata;
      if (w_fire) w_strb_q <= s_axi_wstrb;
      aw_held_q <= wr_go ? 1'b0 : (aw_held_q | aw_fire);
      w_held_q  <= wr_go ? 1'b0 : (w_held_q | w_fire);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= prss_pkg::PRSS_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_known(aw_addr_q) ? prss_pkg::PRSS_RESP_OKAY : prss_pkg::PRSS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= prss_pkg::PRSS_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= cfg_wide[13:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) ratio_q[i] <= prss_pkg::PRSS_RATIO_RESET;
    end else if (wr_ratio) begin
      ratio_q[wr_idx] <= merge(ratio_q[wr_idx], w_data_q, w_strb_q);
    end
  end

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  localparam logic [23:0] LOSS_LAST = 24'(LOSS_WAIT_CYCLES - 1);
  logic [23:0] loss_cnt_q;
  logic        auto_dyn_q;

  wire logic auto_mode = cfg.ratio_select != cfg.dynamic_ratio_select;
  // Manual bit has no say while auto mode runs
  wire logic use_dyn   = auto_mode ? auto_dyn_q : cfg.synth_source_select;

  // Dynamic stays selected for the full wait after the reference vanishes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_cnt_q <= 24'd0;
      auto_dyn_q <= 1'b0;
    end else if (ref_seen) begin
      loss_cnt_q <= 24'd0;
      auto_dyn_q <= 1'b1;
    end else if (auto_dyn_q) begin
      if (loss_cnt_q == LOSS_LAST) begin
        auto_dyn_q <= 1'b0;
        loss_cnt_q <= 24'd0;
      end else begin
        loss_cnt_q <= loss_cnt_q + 24'd1;
      end
    end
  end

  // Manual mode uses the ratio select field; both fields agree there
  wire logic [1:0] sel_idx = (auto_mode && use_dyn) ? cfg.dynamic_ratio_select
                                                    : cfg.ratio_select;
  wire logic [31:0] sel_ratio = cfg.ratio[sel_idx];
  wire logic wide_fmt = use_dyn && !cfg.ratio_format_select;

  logic [31:0] eff_ratio;
  prss_ratio_calc u_calc (
    .aclk                     (aclk),
    .aresetn                  (aresetn),
    .user_ratio               (sel_ratio),
    .manual_modifier_select   (cfg.manual_modifier_select),
    .apply_auto               (use_dyn && cfg.auto_modifier_enable),
    .input_range_indicator    (range_code),
    .wide_format              (wide_fmt),
    .reference_divider_select (cfg.reference_divider_select),
    .effective_ratio          (eff_ratio)
  );

  logic [31:0] frac_q;
  logic        dyn_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frac_q <= 32'h0000_0000;
      dyn_q  <= 1'b0;
    end else begin
      frac_q <= use_dyn ? dpll_ratio : eff_ratio;
      dyn_q  <= use_dyn;
    end
  end
  assign frac_n_value   = frac_q;
  assign frac_n_dynamic = dyn_q;

  // ----------------------------------------------------------------------
  // Clock output gating
  // ----------------------------------------------------------------------
  // Combinational on purpose: a clock cannot be retimed by aclk
  assign pll_clk_out      = synth_clk && (locked || output_on_unlock_enable);
  assign pll_clk_out_en_n = pll_output_disable;

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  assign s_axi_arready = !rvalid_q;
  wire logic ar_fire = s_axi_arvalid && s_axi_arready;
  wire logic [5:0] ra = s_axi_araddr[7:2];
  wire logic [31:0] status_word = {26'd0, dyn_q, auto_mode, locked, range_code, ref_seen};
  wire logic [31:0] rd_mux =
      (ra[5:2] == 4'h0)                         ? ratio_q[ra[1:0]] :
      (ra == prss_pkg::PRSS_OFS_CONFIG[7:2])    ? {18'd0, cfg_q} :
      (ra == prss_pkg::PRSS_OFS_STATUS[7:2])    ? status_word :
      (ra == prss_pkg::PRSS_OFS_EFFECT[7:2])    ? eff_ratio : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= prss_pkg::PRSS_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= addr_known(s_axi_araddr) ? prss_pkg::PRSS_RESP_OKAY : prss_pkg::PRSS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : prss_top
`default_nettype wire
